// ### hw/cwd_config_word.sv
`timescale 1ns/1ns
// Summary of operation
// R1 - The word is 14 bits, bit 13 down to bit 0, at location 2007h.
// R2 - Single-bit variant: protect copies at 13-7 and 5-4, 1 open, 0 all.
// R3 - Protection applies only when every protect copy agrees.
// R4 - Bit 6 at one enables brown-out reset, at zero disables it.
// R5 - Bit 3 is an active-low power-up timer enable.
// R6 - Bit 2 at one enables the watchdog, at zero disables it.
// R7 - Bits 1-0 pick the oscillator: 11 RC, 10 HS, 01 XT, 00 LP.
// R8 - Brown-out reset enabled forces the power-up timer on.
// R9 - The programmer should enable the timer whenever brown-out is on.
// R10 - Paired variant: bits 11-10 pick one of four brown-out levels.
// R11 - Paired variant: protect pairs at 13-12, 9-8, 5-4 must be equal.
// R12 - Positions with no function read back as one.
module cwd_config_word
    import cwd_pkg::*;
#(
    parameter cwd_variant_e VARIANT = CWD_SINGLE
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_wb_cyc,
    input  wire logic                 i_wb_stb,
    input  wire logic                 i_wb_we,
    input  wire logic [CWD_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]           i_wb_sel,
    input  wire logic [CWD_DAT_W-1:0] i_wb_dat,
    output logic      [CWD_DAT_W-1:0] o_wb_dat,
    output logic                      o_wb_ack,
    output logic                      o_brownout_enable,
    output logic                      o_powerup_timer_on,
    output logic                      o_watchdog_enable,
    output logic      [1:0]           o_oscillator_select,
    output logic      [1:0]           o_brownout_voltage_select,
    output logic      [1:0]           o_protect_code,
    output logic                      o_protect_agree,
    output logic                      o_protect_active,
    output logic                      o_protect_low_exempt
);

    ////////////////////////////////////////////////////////////////////////
    // Variant constants
    localparam logic [13:0] UNIMP = (VARIANT == CWD_PAIRED) ?
                                    CWD_UNIMP_PAIRED : CWD_UNIMP_SINGLE;

    // Whole module state in one record
    typedef struct packed {
        logic [13:0]          word;
        logic                 ack;
        logic [CWD_DAT_W-1:0] rdata;
        logic                 brown_en;
        logic                 timer_on;
        logic                 wdog_en;
        cwd_osc_e             osc;
        logic [1:0]           trip_sel;
        cwd_prot_e            prot;
        logic                 agree;
        logic                 active;
        logic                 exempt;
    } cwd_state_s;

    // Decoded values of the erased word, matching the decoders
    localparam cwd_state_s ST_RESET = '{
        word:    CWD_WORD_RESET,
        ack:     1'b0,
        rdata:   32'h0000_0000,
        brown_en: 1'b1,
        timer_on: 1'b1,
        wdog_en:  1'b1,
        osc:      CWD_OSC_RC,
        trip_sel: (VARIANT == CWD_PAIRED) ? 2'h3 : 2'h0,
        prot:    CWD_PROT_OFF,
        agree:   1'b1,
        active:  1'b0,
        exempt:  1'b0
    };

    cwd_state_s st;
    cwd_state_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // Field decoders working on the stored word
    logic       dec_brown;
    logic       dec_timer;
    logic       dec_wdog;
    cwd_osc_e   dec_osc;
    logic [1:0] dec_trip;
    cwd_prot_e  dec_prot;
    logic       dec_agree;
    logic       dec_active;
    logic       dec_exempt;

    cwd_supervisor_dec #(
        .VARIANT(VARIANT)
    ) u_supervisor (
        .i_word                    (st.word),
        .o_brownout_enable         (dec_brown),
        .o_powerup_timer_on        (dec_timer),
        .o_watchdog_enable         (dec_wdog),
        .o_oscillator_select       (dec_osc),
        .o_brownout_voltage_select (dec_trip)
    );

    cwd_protect_dec #(
        .VARIANT(VARIANT)
    ) u_protect (
        .i_word       (st.word),
        .o_code       (dec_prot),
        .o_agree      (dec_agree),
        .o_active     (dec_active),
        .o_low_exempt (dec_exempt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic        req;
    logic        hit_cfg;
    logic        hit_stat;
    logic [13:0] wr_word;
    logic [31:0] stat_word;

    // One new request per ack; the cycle with ack high blocks a repeat
    assign req      = i_wb_cyc && i_wb_stb && !st.ack;
    assign hit_cfg  = (i_wb_adr[CWD_ADR_W-1:2] == CWD_CFG_INDEX); // R1
    assign hit_stat = (i_wb_adr[CWD_ADR_W-1:2] == CWD_STAT_INDEX);

    // Byte lanes 0 and 1 cover the 14 bits; unused cells stay one
    always_comb begin
        wr_word = st.word;
        if (i_wb_sel[0]) begin
            wr_word[7:0] = i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
            wr_word[13:8] = i_wb_dat[13:8]; // R1
        end
        wr_word = wr_word | UNIMP; // R12
    end

    // Read-only view of the registered decode that the outputs currently drive
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[CWD_ST_OSC_LSB +: 2]  = st.osc;
        stat_word[CWD_ST_WDOG]          = st.wdog_en;
        stat_word[CWD_ST_TIMER]         = st.timer_on;
        stat_word[CWD_ST_BROWN]         = st.brown_en;
        stat_word[CWD_ST_TRIP_LSB +: 2] = st.trip_sel;
        stat_word[CWD_ST_PROT_LSB +: 2] = st.prot;
        stat_word[CWD_ST_AGREE]         = st.agree;
        stat_word[CWD_ST_ACTIVE]        = st.active;
        stat_word[CWD_ST_EXEMPT]        = st.exempt;
        stat_word[CWD_ST_VARIANT]       = VARIANT;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        // Ack lasts one cycle; unmapped addresses answer with zero data
        next_st.ack = req;
        if (req && !i_wb_we) begin
            if (hit_cfg) begin
                next_st.rdata = {18'h0, st.word | UNIMP}; // R1 R12
            end else if (hit_stat) begin
                next_st.rdata = stat_word;
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
        // Writes to the status view or unmapped space are dropped
        if (req && i_wb_we && hit_cfg) begin
            next_st.word = wr_word;
        end
        // Decoded fields follow the word one cycle later
        next_st.brown_en = dec_brown; // R4
        next_st.timer_on = dec_timer; // R8
        next_st.wdog_en  = dec_wdog; // R6
        next_st.osc      = dec_osc; // R7
        next_st.trip_sel = dec_trip; // R10
        next_st.prot    = dec_prot; // R3
        next_st.agree   = dec_agree;
        next_st.active  = dec_active;
        next_st.exempt  = dec_exempt; // R2
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state record
    assign o_wb_dat                  = st.rdata;
    assign o_wb_ack                  = st.ack;
    assign o_brownout_enable         = st.brown_en;
    assign o_powerup_timer_on        = st.timer_on;
    assign o_watchdog_enable         = st.wdog_en;
    assign o_oscillator_select       = st.osc;
    assign o_brownout_voltage_select = st.trip_sel;
    assign o_protect_code            = st.prot;
    assign o_protect_agree           = st.agree;
    assign o_protect_active          = st.active;
    assign o_protect_low_exempt      = st.exempt;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [13:0] prot_copies;
    logic        copies_match;

    // Independent replica test, kept apart from the decoder
    always_comb begin
        prot_copies = st.word & CWD_PROT_MASK_SINGLE;
        if (VARIANT == CWD_SINGLE) begin
            copies_match = (prot_copies == 14'h0000) ||
                           (prot_copies == CWD_PROT_MASK_SINGLE);
        end else begin
            copies_match = (st.word[13:12] == st.word[5:4]) &&
                           (st.word[9:8] == st.word[5:4]);
        end
    end

    a_word_width: assert property ( // R1
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && !i_wb_we && hit_cfg) |=>
            o_wb_ack && o_wb_dat[31:14] == 18'h0
    ) else $error("config read shows bits above 13");

    a_readback_ones: assert property ( // R12
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && !i_wb_we && hit_cfg) |=>
            (o_wb_dat[13:0] & UNIMP) == UNIMP
    ) else $error("unused config position read as zero");

    a_write_lands: assert property ( // R1
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && i_wb_we && hit_cfg && i_wb_sel[1:0] == 2'h3) |=>
            st.word == ($past(i_wb_dat[13:0]) | UNIMP) ##1
            o_brownout_enable == st.word[CWD_BROWN_BIT]
    ) else $error("config write not stored or decoded");

    a_single_all: assert property ( // R2
        @(posedge i_clk) disable iff (!i_arst_n)
        (VARIANT == CWD_SINGLE && prot_copies == 14'h0000) |=>
            o_protect_active && o_protect_low_exempt &&
            o_protect_code == CWD_PROT_ALL
    ) else $error("single-bit protect not applied");

    a_protect_agree: assert property ( // R3
        @(posedge i_clk) disable iff (!i_arst_n)
        !copies_match |=>
            !o_protect_active && o_protect_code == CWD_PROT_OFF &&
            !o_protect_agree
    ) else $error("protection applied with split copies");

    a_pair_code: assert property ( // R11
        @(posedge i_clk) disable iff (!i_arst_n)
        (VARIANT == CWD_PAIRED && copies_match) |=>
            o_protect_code == $past(st.word[5:4]) &&
            o_protect_active == ($past(st.word[5:4]) != 2'h3)
    ) else $error("paired protect code wrong");

    a_brownout_bit: assert property ( // R4
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 o_brownout_enable == $past(st.word[CWD_BROWN_BIT])
    ) else $error("brown-out enable does not follow bit 6");

    a_powerup_bit: assert property ( // R5
        @(posedge i_clk) disable iff (!i_arst_n)
        !st.word[CWD_BROWN_BIT] |=>
            o_powerup_timer_on == !$past(st.word[CWD_TIMER_BIT])
    ) else $error("power-up timer does not follow bit 3");

    a_powerup_forced: assert property ( // R8
        @(posedge i_clk) disable iff (!i_arst_n)
        o_brownout_enable |-> o_powerup_timer_on
    ) else $error("brown-out on without power-up timer");

    a_watchdog_bit: assert property ( // R6
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 o_watchdog_enable == $past(st.word[CWD_WDOG_BIT])
    ) else $error("watchdog enable does not follow bit 2");

    a_osc_select: assert property ( // R7
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 o_oscillator_select == $past(st.word[1:0])
    ) else $error("oscillator select does not follow bits 1-0");

    a_trip_level: assert property ( // R10
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 o_brownout_voltage_select ==
            ((VARIANT == CWD_PAIRED) ? $past(st.word[11:10]) : 2'h0)
    ) else $error("brown-out level code wrong");

    a_ack_single: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        o_wb_ack |=> !o_wb_ack
    ) else $error("bus ack held two cycles");

    a_ack_taken: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        req |=> o_wb_ack
    ) else $error("request taken without ack");

    a_ack_idle: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !req |=> !o_wb_ack
    ) else $error("ack without a request");

    a_write_dropped: assert property ( // R1
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && i_wb_we && !hit_cfg) |=> $stable(st.word)
    ) else $error("stray write changed the word");

    a_unmapped_zero: assert property ( // R1
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && !i_wb_we && !hit_cfg && !hit_stat) |=>
            o_wb_dat == 32'h0000_0000
    ) else $error("unmapped read returned data");

    a_status_image: assert property ( // R8
        @(posedge i_clk) disable iff (!i_arst_n)
        (req && !i_wb_we && hit_stat) |=>
            o_wb_dat[CWD_ST_TIMER] == $past(o_powerup_timer_on) &&
            o_wb_dat[CWD_ST_BROWN] == $past(o_brownout_enable) &&
            o_wb_dat[31:13] == 19'h0
    ) else $error("status view differs from decode");

    a_exempt_single: assert property ( // R2
        @(posedge i_clk) disable iff (!i_arst_n)
        o_protect_low_exempt |->
            VARIANT == CWD_SINGLE && o_protect_code == CWD_PROT_ALL
    ) else $error("low block exempt out of scheme");

    a_pair_agree: assert property ( // R11
        @(posedge i_clk) disable iff (!i_arst_n)
        (VARIANT == CWD_PAIRED && copies_match) |=> o_protect_agree
    ) else $error("equal pairs not flagged");

    a_unused_ones: assert property ( // R12
        @(posedge i_clk) disable iff (!i_arst_n)
        (st.word & UNIMP) == UNIMP
    ) else $error("unused position stored as zero");

endmodule

// ### hw/cwd_pkg.sv
package cwd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned CWD_ADR_W  = 16;
    localparam int unsigned CWD_DAT_W  = 32;
    localparam int unsigned CWD_WORD_W = 14;

    // Register indices, byte address is four times the index
    localparam logic [13:0] CWD_CFG_INDEX  = 14'h2007;
    localparam logic [13:0] CWD_STAT_INDEX = 14'h2008;

    ////////////////////////////////////////////////////////////////////////
    // Configuration word fields
    localparam int unsigned CWD_OSC_LSB   = 0;
    localparam int unsigned CWD_WDOG_BIT  = 2;
    localparam int unsigned CWD_TIMER_BIT = 3;
    localparam int unsigned CWD_BROWN_BIT = 6;
    localparam int unsigned CWD_TRIP_LSB  = 10;
    localparam int unsigned CWD_PAIR_LO   = 4;
    localparam int unsigned CWD_PAIR_MID  = 8;
    localparam int unsigned CWD_PAIR_HI   = 12;

    // Protect copies of the single-bit variant: bits 13-7 and 5-4
    localparam logic [13:0] CWD_PROT_MASK_SINGLE = 14'h3fb0;
    // Positions with no function, forced to one on read-back
    localparam logic [13:0] CWD_UNIMP_SINGLE     = 14'h0000;
    localparam logic [13:0] CWD_UNIMP_PAIRED     = 14'h0080;

    // Erased word: every cell reads one
    localparam logic [13:0] CWD_WORD_RESET = 14'h3fff;

    ////////////////////////////////////////////////////////////////////////
    // Decoded status register layout
    localparam int unsigned CWD_ST_OSC_LSB  = 0;
    localparam int unsigned CWD_ST_WDOG     = 2;
    localparam int unsigned CWD_ST_TIMER    = 3;
    localparam int unsigned CWD_ST_BROWN    = 4;
    localparam int unsigned CWD_ST_TRIP_LSB = 5;
    localparam int unsigned CWD_ST_PROT_LSB = 7;
    localparam int unsigned CWD_ST_AGREE    = 9;
    localparam int unsigned CWD_ST_ACTIVE   = 10;
    localparam int unsigned CWD_ST_EXEMPT   = 11;
    localparam int unsigned CWD_ST_VARIANT  = 12;

    ////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic {
        CWD_SINGLE = 1'b0,
        CWD_PAIRED = 1'b1
    } cwd_variant_e;

    typedef enum logic [1:0] {
        CWD_OSC_LP = 2'h0,
        CWD_OSC_XT = 2'h1,
        CWD_OSC_HS = 2'h2,
        CWD_OSC_RC = 2'h3
    } cwd_osc_e;

    typedef enum logic [1:0] {
        CWD_PROT_ALL   = 2'h0,
        CWD_PROT_UP3Q  = 2'h1,
        CWD_PROT_UPHLF = 2'h2,
        CWD_PROT_OFF   = 2'h3
    } cwd_prot_e;

endpackage

// ### hw/cwd_protect_dec.sv
`timescale 1ns/1ns
module cwd_protect_dec
    import cwd_pkg::*;
#(
    parameter cwd_variant_e VARIANT = CWD_SINGLE
) (
    input  wire logic [13:0] i_word,
    output cwd_prot_e        o_code,
    output logic             o_agree,
    output logic             o_active,
    output logic             o_low_exempt
);

    ////////////////////////////////////////////////////////////////////////
    // Replica check and scheme select
    always_comb begin
        logic [13:0] copies;
        logic [1:0]  lo;
        copies = i_word & CWD_PROT_MASK_SINGLE;
        lo     = i_word[CWD_PAIR_LO +: 2];
        if (VARIANT == CWD_SINGLE) begin
            // Every copy of the one bit must match
            o_agree = (copies == 14'h0000) ||
                      (copies == CWD_PROT_MASK_SINGLE); // R3
            o_code  = (o_agree && copies == 14'h0000) ?
                      CWD_PROT_ALL : CWD_PROT_OFF; // R2
        end else begin
            // Three pairs must carry one pattern
            o_agree = (i_word[CWD_PAIR_HI +: 2] == lo) &&
                      (i_word[CWD_PAIR_MID +: 2] == lo); // R11
            // Disagreeing copies leave memory open
            o_code  = o_agree ? cwd_prot_e'(lo) : CWD_PROT_OFF; // R3
        end
        o_active     = (o_code != CWD_PROT_OFF);
        // Low block stays writable in the single-bit scheme only
        o_low_exempt = o_active && (VARIANT == CWD_SINGLE); // R2
    end

endmodule

// ### hw/cwd_supervisor_dec.sv
`timescale 1ns/1ns
module cwd_supervisor_dec
    import cwd_pkg::*;
#(
    parameter cwd_variant_e VARIANT = CWD_SINGLE
) (
    input  wire logic [13:0] i_word,
    output logic             o_brownout_enable,
    output logic             o_powerup_timer_on,
    output logic             o_watchdog_enable,
    output cwd_osc_e         o_oscillator_select,
    output logic [1:0]       o_brownout_voltage_select
);

    ////////////////////////////////////////////////////////////////////////
    // Reset, timer and clock source fields
    always_comb begin
        o_brownout_enable   = i_word[CWD_BROWN_BIT]; // R4
        // Brown-out needs a settled supply, so it drags the timer on
        o_powerup_timer_on  = !i_word[CWD_TIMER_BIT] ||
                              o_brownout_enable; // R5 R8
        o_watchdog_enable   = i_word[CWD_WDOG_BIT]; // R6
        o_oscillator_select = cwd_osc_e'(i_word[CWD_OSC_LSB +: 2]); // R7
        // Trip level code passed raw by the paired variant, zero in the single-bit one; its level table sits downstream
        if (VARIANT == CWD_PAIRED) begin
            o_brownout_voltage_select = i_word[CWD_TRIP_LSB +: 2]; // R10
        end else begin
            o_brownout_voltage_select = 2'h0;
        end
    end

endmodule

// ### testbench/cwd_prog_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Programmer model: classic single-cycle bus master
module cwd_prog_model
    import cwd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_ack_s,
    input  wire logic        i_ack_p,
    input  wire logic [31:0] i_dat_s,
    input  wire logic [31:0] i_dat_p,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic      [15:0] o_adr,
    output logic      [3:0]  o_sel,
    output logic      [31:0] o_dat
);
    // Idle bus from time zero
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we  = 1'b0;
        o_adr = 16'h0000;
        o_sel = 4'h0;
        o_dat = 32'h0000_0000;
    end

    // One transfer; call right after a rising edge, returns after one idle
    task automatic wb_xfer(input logic we, input logic [15:0] adr,
                           input logic [31:0] dat, output logic [31:0] rs,
                           output logic [31:0] rp, output bit ok);
        int n;
        ok = 1'b0;
        rs = 32'h0000_0000;
        rp = 32'h0000_0000;
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we  <= we;
        o_adr <= adr;
        o_sel <= 4'hf;
        o_dat <= dat;
        // Bounded wait, no latency assumed
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (i_ack_s === 1'b1 && i_ack_p === 1'b1) begin
                ok = 1'b1;
                rs = i_dat_s;
                rp = i_dat_p;
                break;
            end
        end
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we  <= 1'b0;
        @(posedge i_clk);
    endtask

    // Whole word in one access, so all protect copies land together
    task automatic program_word(input logic [13:0] w, input bit strict,
                                output logic [13:0] wr, output bit ok);
        logic [31:0] rs;
        logic [31:0] rp;
        wr = w;
        if (strict && w[6]) begin
            wr[3] = 1'b0;
        end
        wb_xfer(1'b1, 16'h801c, {18'h0, wr}, rs, rp, ok);
    endtask
endmodule

// ### testbench/cwd_config_word_test.sv
`timescale 1ns/1ns
module cwd_config_word_test
    import cwd_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rd [2];
    logic [1:0]  ack;
    logic [1:0]  brn;
    logic [1:0]  tmr;
    logic [1:0]  wdg;
    logic [1:0]  agree;
    logic [1:0]  act;
    logic [1:0]  exm;
    logic [1:0]  osc [2];
    logic [1:0]  lvl [2];
    logic [1:0]  code [2];
    logic [11:0] dec [2];
    logic [13:0] last_w;
    int          n_fail;
    int          compares;

    ////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Both variants share the bus, so each access hits both
    cwd_config_word #(.VARIANT(CWD_SINGLE)) cwd_config_word_i (
        .i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rd[0]), .o_wb_ack(ack[0]), .o_brownout_enable(brn[0]),
        .o_powerup_timer_on(tmr[0]), .o_watchdog_enable(wdg[0]),
        .o_oscillator_select(osc[0]), .o_brownout_voltage_select(lvl[0]),
        .o_protect_code(code[0]), .o_protect_agree(agree[0]),
        .o_protect_active(act[0]), .o_protect_low_exempt(exm[0]));
    cwd_config_word #(.VARIANT(CWD_PAIRED)) cwd_config_word_paired_i (
        .i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rd[1]), .o_wb_ack(ack[1]), .o_brownout_enable(brn[1]),
        .o_powerup_timer_on(tmr[1]), .o_watchdog_enable(wdg[1]),
        .o_oscillator_select(osc[1]), .o_brownout_voltage_select(lvl[1]),
        .o_protect_code(code[1]), .o_protect_agree(agree[1]),
        .o_protect_active(act[1]), .o_protect_low_exempt(exm[1]));
    cwd_prog_model cwd_prog_model_i (
        .i_clk(clk), .i_ack_s(ack[0]), .i_ack_p(ack[1]),
        .i_dat_s(rd[0]), .i_dat_p(rd[1]), .o_cyc(cyc), .o_stb(stb),
        .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

    // Decoded outputs gathered per instance
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dec[i] = {brn[i], tmr[i], wdg[i], osc[i], lvl[i], code[i],
                      agree[i], act[i], exm[i]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected decode worked out from the field layout
    function automatic logic [11:0] exp_dec(input logic [13:0] w,
                                            input bit pr);
        logic [13:0] c;
        logic        ag;
        logic [1:0]  cd;
        c  = w & 14'h3fb0;
        ag = pr ? (w[13:12] == w[9:8] && w[9:8] == w[5:4])
                : (c == 14'h0000 || c == 14'h3fb0);
        cd = !ag ? 2'h3 : pr ? w[5:4] : (c == 14'h0000 ? 2'h0 : 2'h3);
        return {w[6], !w[3] | w[6], w[2], w[1:0], pr ? w[11:10] : 2'h0,
                cd, ag, cd != 2'h3, !pr && cd == 2'h0};
    endfunction

    // Status register image of a decode
    function automatic logic [31:0] exp_st(input logic [11:0] e,
                                           input bit pr);
        return {19'h0, pr, e[0], e[1], e[2], e[4:3], e[6:5], e[11], e[10],
                e[9], e[8:7]};
    endfunction

    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_dec(input logic [11:0] got, input logic [11:0] ex);
        compares++;
        if (got !== ex) begin
            n_fail++;
            $display("wrong value at %0t: decode %h, want %h", $time, got, ex);
        end
    endtask

    task automatic check_rd(input logic [31:0] got, input logic [31:0] ex);
        compares++;
        if (got !== ex) begin
            n_fail++;
            $display("wrong value at %0t: read %h, want %h", $time, got, ex);
        end
    endtask

    // Hang on the bus ends the run
    task automatic check_ok(input bit ok);
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: no acknowledge", $time);
            report_and_stop();
        end
    endtask

    task automatic bus(input logic we_b, input logic [15:0] a,
                       output logic [31:0] rs, output logic [31:0] rp);
        bit ok;
        cwd_prog_model_i.wb_xfer(we_b, a, 32'h0000_0000, rs, rp, ok);
        check_ok(ok);
    endtask

    // Program a word, then check decode, read-back and status of both
    task automatic apply(input logic [13:0] w, input bit strict);
        logic [31:0] rs;
        logic [31:0] rp;
        bit          ok;
        cwd_prog_model_i.program_word(w, strict, last_w, ok);
        check_ok(ok);
        check_dec(dec[0], exp_dec(last_w, 1'b0));
        check_dec(dec[1], exp_dec(last_w, 1'b1));
        bus(1'b0, 16'h801c, rs, rp);
        check_rd(rs, {18'h0, last_w});
        check_rd(rp, {18'h0, last_w | 14'h0080});
        bus(1'b0, 16'h8020, rs, rp);
        check_rd(rs, exp_st(exp_dec(last_w, 1'b0), 1'b0));
        check_rd(rp, exp_st(exp_dec(last_w, 1'b1), 1'b1));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [13:0] w;
        logic [31:0] rs;
        logic [31:0] rp;
        logic [13:0] pw [5];
        n_fail   = 0;
        compares = 0;
        arst_n   = 1'b0;
        pw = '{14'h004f, 14'h266f, 14'h195f, 14'h204f, 14'h3fff};
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Erased word after reset
        check_dec(dec[0], exp_dec(14'h3fff, 1'b0));
        check_dec(dec[1], exp_dec(14'h3fff, 1'b1));
        bus(1'b0, 16'h801c, rs, rp);
        check_rd(rs, 32'h0000_3fff);
        check_rd(rp, 32'h0000_3fff);
        // Every oscillator, watchdog and brown-out/timer pairing;
        // brown-out on with timer off is sent on purpose
        for (int k = 0; k < 16; k++) begin
            w      = 14'h3fb0;
            w[6]   = k[3] ^ k[1];
            w[3]   = k[3];
            w[2]   = k[2];
            w[1:0] = k[1:0];
            apply(w, 1'b0);
        end
        // Protect patterns: all zero, pairs 10 and 01, one stray copy
        for (int k = 0; k < 5; k++) begin
            apply(pw[k], 1'b1);
        end
        // Unmapped and read-only places leave the word alone
        bus(1'b1, 16'h8024, rs, rp);
        bus(1'b1, 16'h8020, rs, rp);
        bus(1'b0, 16'h8024, rs, rp);
        check_rd(rs, 32'h0000_0000);
        check_rd(rp, 32'h0000_0000);
        bus(1'b0, 16'h801c, rs, rp);
        check_rd(rs, {18'h0, last_w});
        // Reset in mid-run returns the erased word
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check_dec(dec[0], exp_dec(14'h3fff, 1'b0));
        check_dec(dec[1], exp_dec(14'h3fff, 1'b1));
        bus(1'b0, 16'h801c, rs, rp);
        check_rd(rp, 32'h0000_3fff);
        report_and_stop();
    end
endmodule
